// ===== design/alu_pkg.sv
package alu_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          DATA_W    = 8;
    localparam int          ADDR_W    = 8;
    localparam int          NIBBLE_W  = 4;
    localparam logic [7:0]  ACCUMULATOR_RESET = 8'h00;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE            = 3'h0,
        OP_ADD_TO_MEMORY   = 3'h1,
        OP_AND_FROM_MEMORY = 3'h3,
        OP_AND_IMMEDIATE   = 3'h2,
        OP_AND_TO_MEMORY   = 3'h6
    } alu_op_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                valid;
        alu_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   mem_data;
        logic [DATA_W-1:0]   imm;
    } alu_req_s;

    // Bit order: overflow, zero, aux carry, carry, signed compare
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
        logic signed_compare_flag;
    } flags_s;

    typedef struct packed {
        flags_s val;
        flags_s en;
    } flag_upd_s;

    typedef struct packed {
        logic                we;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } mem_wr_s;

    localparam flags_s FLAG_EN_NONE = flags_s'(5'h00);
    localparam flags_s FLAG_EN_ZERO = flags_s'(5'h08);
    localparam flags_s FLAG_EN_ALL  = flags_s'(5'h1f);

endpackage : alu_pkg

// ===== design/alu_add_flags.sv
module alu_add_flags
    import alu_pkg::*;
#(
    parameter int W   = DATA_W,
    parameter int NIB = NIBBLE_W
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic      [W-1:0] sum,
    output flags_s            flags
);

    logic [W:0]   full;
    logic [NIB:0] low;

    // ------------------------------------------------------------
    // Sum with carry out of the low nibble and of the top bit
    // ------------------------------------------------------------
    always_comb begin
        full  = {1'b0, a} + {1'b0, b};
        low   = {1'b0, a[NIB-1:0]} + {1'b0, b[NIB-1:0]};
        sum   = full[W-1:0];
        flags.overflow_flag  = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
        flags.zero_flag      = (sum == '0);
        flags.aux_carry_flag = low[NIB];
        flags.carry_flag     = full[W];
        flags.signed_compare_flag = flags.overflow_flag ^ sum[W-1];
    end

endmodule : alu_add_flags

// ===== design/alu_datapath.sv
// Functional notes
// RQ1: Add-to-memory adds accumulator and memory byte, updates all five flags.
// RQ2: Add-to-memory sum goes back to same address; accumulator unchanged.
// RQ3: AND-from-memory loads accumulator AND memory byte; only zero flag.
// RQ4: AND-immediate loads accumulator AND immediate; only zero flag updated.
// RQ5: AND-to-memory computes memory byte AND accumulator.
// RQ6: AND-to-memory result is written to memory, not the accumulator.
// RQ7: AND-to-memory updates zero flag from result; other flags untouched.
module alu_datapath
    import alu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire alu_req_s          req,
    input  wire logic              accumulator_load_valid,
    input  wire logic [DATA_W-1:0] accumulator_load_data,
    output logic      [DATA_W-1:0] accumulator,
    output mem_wr_s                mem_wr,
    output flag_upd_s              flag_upd,
    output logic                   done
);

    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    function automatic logic is_op(input alu_req_s r, input alu_op_e o);
        return r.valid && (r.op == o);
    endfunction : is_op

    logic [DATA_W-1:0] add_sum;
    flags_s            add_flags;
    logic [DATA_W-1:0] and_mem;
    logic [DATA_W-1:0] and_imm;

    alu_add_flags #(
        .W   (DATA_W),
        .NIB (NIBBLE_W)
    ) u_add (
        .a     (accumulator),
        .b     (req.mem_data),
        .sum   (add_sum),
        .flags (add_flags)
    );

    always_comb begin
        and_mem = accumulator & req.mem_data;
        and_imm = accumulator & req.imm;
    end

    // ------------------------------------------------------------
    // Next-state computation
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_accumulator;
    mem_wr_s           next_mem_wr;
    flag_upd_s         next_flag_upd;
    logic              next_done;

    always_comb begin
        next_accumulator  = accumulator;
        next_mem_wr.we    = 1'b0;
        next_mem_wr.addr  = req.addr;
        next_mem_wr.data  = ZERO_BYTE;
        next_flag_upd.val = FLAG_EN_NONE;
        next_flag_upd.en  = FLAG_EN_NONE;
        next_done         = 1'b0;
        if (is_op(req, OP_ADD_TO_MEMORY)) begin
            next_mem_wr.we    = 1'b1;                        // RQ2
            next_mem_wr.data  = add_sum;                     // RQ1
            next_flag_upd.val = add_flags;                   // RQ1
            next_flag_upd.en  = FLAG_EN_ALL;                 // RQ1
            next_done         = 1'b1;
        end else if (is_op(req, OP_AND_FROM_MEMORY)) begin
            next_accumulator  = and_mem;                     // RQ3
            next_flag_upd.val.zero_flag = (and_mem == '0);   // RQ3
            next_flag_upd.en  = FLAG_EN_ZERO;                // RQ3
            next_done         = 1'b1;
        end else if (is_op(req, OP_AND_IMMEDIATE)) begin
            next_accumulator  = and_imm;                     // RQ4
            next_flag_upd.val.zero_flag = (and_imm == '0);   // RQ4
            next_flag_upd.en  = FLAG_EN_ZERO;                // RQ4
            next_done         = 1'b1;
        end else if (is_op(req, OP_AND_TO_MEMORY)) begin
            next_mem_wr.we    = 1'b1;                        // RQ6
            next_mem_wr.data  = and_mem;                     // RQ5
            next_flag_upd.val.zero_flag = (and_mem == '0);   // RQ7
            next_flag_upd.en  = FLAG_EN_ZERO;                // RQ7
            next_done         = 1'b1;
        end else if (accumulator_load_valid) begin
            // Loads from other instructions only when no defined op is issued
            next_accumulator  = accumulator_load_data;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accumulator       <= ACCUMULATOR_RESET;
            mem_wr.we         <= 1'b0;
            mem_wr.addr       <= '0;
            mem_wr.data       <= ZERO_BYTE;
            flag_upd          <= '0;
            done              <= 1'b0;
        end else begin
            accumulator       <= next_accumulator;
            mem_wr            <= next_mem_wr;
            flag_upd          <= next_flag_upd;
            done              <= next_done;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_add_req;
        is_op(req, OP_ADD_TO_MEMORY);
    endsequence

    sequence s_and_mem_req;
        is_op(req, OP_AND_FROM_MEMORY);
    endsequence

    sequence s_and_imm_req;
        is_op(req, OP_AND_IMMEDIATE);
    endsequence

    sequence s_and_to_mem_req;
        is_op(req, OP_AND_TO_MEMORY);
    endsequence

    property p_add_sum;
        @(posedge clk) disable iff (!rst_n)
        s_add_req |=> mem_wr.we && done
            && (mem_wr.data
                == DATA_W'($past(accumulator) + $past(req.mem_data)));
    endproperty
    a_add_sum: assert property (p_add_sum) // RQ1
        else $error("add-to-memory sum wrong");

    property p_add_flags;
        @(posedge clk) disable iff (!rst_n)
        s_add_req |=> (flag_upd.en == FLAG_EN_ALL)
            && (flag_upd.val.zero_flag == (mem_wr.data == ZERO_BYTE))
            && (flag_upd.val.carry_flag
                == ((9'($past(accumulator)) + 9'($past(req.mem_data)))
                    > 9'h0ff));
    endproperty
    a_add_flags: assert property (p_add_flags) // RQ1
        else $error("add-to-memory flags wrong");

    property p_add_dest;
        @(posedge clk) disable iff (!rst_n)
        s_add_req |=> (mem_wr.addr == $past(req.addr))
            && (accumulator == $past(accumulator));
    endproperty
    a_add_dest: assert property (p_add_dest) // RQ2
        else $error("add-to-memory destination wrong");

    property p_and_from_mem;
        @(posedge clk) disable iff (!rst_n)
        s_and_mem_req |=> !mem_wr.we
            && (accumulator == ($past(accumulator) & $past(req.mem_data)))
            && (flag_upd.en == FLAG_EN_ZERO)
            && (flag_upd.val.zero_flag == (accumulator == ZERO_BYTE));
    endproperty
    a_and_from_mem: assert property (p_and_from_mem) // RQ3
        else $error("AND-from-memory result or flags wrong");

    property p_and_imm;
        @(posedge clk) disable iff (!rst_n)
        s_and_imm_req |=> !mem_wr.we
            && (accumulator == ($past(accumulator) & $past(req.imm)))
            && (flag_upd.en == FLAG_EN_ZERO)
            && (flag_upd.val.zero_flag == (accumulator == ZERO_BYTE));
    endproperty
    a_and_imm: assert property (p_and_imm) // RQ4
        else $error("AND-immediate result or flags wrong");

    property p_and_to_mem_data;
        @(posedge clk) disable iff (!rst_n)
        s_and_to_mem_req |=>
            (mem_wr.data == ($past(accumulator) & $past(req.mem_data)));
    endproperty
    a_and_to_mem_data: assert property (p_and_to_mem_data) // RQ5
        else $error("AND-to-memory result wrong");

    property p_and_to_mem_dest;
        @(posedge clk) disable iff (!rst_n)
        s_and_to_mem_req |=> mem_wr.we
            && (mem_wr.addr == $past(req.addr))
            && (accumulator == $past(accumulator));
    endproperty
    a_and_to_mem_dest: assert property (p_and_to_mem_dest) // RQ6
        else $error("AND-to-memory destination wrong");

    property p_and_to_mem_flags;
        @(posedge clk) disable iff (!rst_n)
        s_and_to_mem_req |=> (flag_upd.en == FLAG_EN_ZERO)
            && (flag_upd.val.zero_flag == (mem_wr.data == ZERO_BYTE));
    endproperty
    a_and_to_mem_flags: assert property (p_and_to_mem_flags) // RQ7
        else $error("AND-to-memory zero flag wrong");

    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_n)
        !req.valid |=> !mem_wr.we && !done
            && (flag_upd.en == FLAG_EN_NONE);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("output activity without a request");

    property p_add_flags_rest;
        @(posedge clk) disable iff (!rst_n)
        s_add_req |=> (flag_upd.val.overflow_flag
                == (($past(accumulator[7]) == $past(req.mem_data[7]))
                    && (mem_wr.data[7] != $past(accumulator[7]))))
            && (flag_upd.val.aux_carry_flag
                == ((5'($past(accumulator[3:0]))
                     + 5'($past(req.mem_data[3:0]))) > 5'h0f))
            && (flag_upd.val.signed_compare_flag
                == (flag_upd.val.overflow_flag ^ mem_wr.data[7]));
    endproperty
    a_add_flags_rest: assert property (p_add_flags_rest) // RQ1
        else $error("add-to-memory overflow, aux or compare flag wrong");

    property p_accumulator_load;
        @(posedge clk) disable iff (!rst_n)
        accumulator_load_valid && !req.valid
            |=> (accumulator == $past(accumulator_load_data));
    endproperty
    a_accumulator_load: assert property (p_accumulator_load)
        else $error("accumulator load lost");

    property p_reset_clears;
        @(posedge clk)
        !rst_n |=> (accumulator == ACCUMULATOR_RESET) && !mem_wr.we
            && !done && (flag_upd == '0);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left an output set");

endmodule : alu_datapath

// ===== testbench/data_memory_model.sv
// ------------------------------------------------------------
// Data memory seen by the datapath: async read, write on edge
// ------------------------------------------------------------
module data_memory_model
    import alu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire mem_wr_s           wr,
    output logic      [DATA_W-1:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] mem [256];

    // Preset to the inverted address so every byte differs
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~8'(i);
        end
    end

    always @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
    end

    assign rd_data = mem[addr];
endmodule : data_memory_model

// ===== testbench/test_add_and_memory_alu_ops.sv
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module test_add_and_memory_alu_ops
    import alu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst_n, r_valid, ld_valid, done;
    alu_op_e    r_op;
    logic [7:0] r_addr, r_imm, ld_data, rd_data, exp_accumulator;
    logic [7:0] accumulator;
    logic [7:0] mem_exp [256];
    alu_req_s   req;
    mem_wr_s    mem_wr;
    flag_upd_s  flag_upd;
    int         miscompares, compares;

    assign req = '{valid: r_valid, op: r_op, addr: r_addr,
                   mem_data: rd_data, imm: r_imm};

    alu_datapath u_dut (.clk(clk), .rst_n(rst_n), .req(req),
        .accumulator_load_valid(ld_valid),
        .accumulator_load_data(ld_data),
        .accumulator(accumulator), .mem_wr(mem_wr),
        .flag_upd(flag_upd), .done(done));

    data_memory_model u_mem (.clk(clk), .addr(r_addr), .wr(mem_wr),
        .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic load(input logic [7:0] v);
        ld_valid = 1'b1;
        ld_data = v;
        @(negedge clk);
        ld_valid = 1'b0;
        exp_accumulator = v;
        chk(accumulator, exp_accumulator);
        chk(done, 1'b0);
    endtask : load

    // Issues one op, leaves valid high so calls run back to back
    task automatic exec(input alu_op_e op, input logic [7:0] a, imm);
        logic [8:0] s;
        logic [7:0] r, m, x;
        flags_s     f;
        logic       w;
        m = mem_exp[a];
        s = {1'b0, exp_accumulator} + {1'b0, m};
        f = FLAG_EN_NONE;
        w = (op != OP_AND_FROM_MEMORY) && (op != OP_AND_IMMEDIATE);
        r = exp_accumulator & m;
        if (op == OP_ADD_TO_MEMORY) begin
            r = s[7:0];
            x = exp_accumulator ^ m ^ r;
            f.overflow_flag = (exp_accumulator[7] == m[7]) && (r[7] != m[7]);
            f.aux_carry_flag = x[4];
            f.carry_flag = s[8];
            f.signed_compare_flag = f.overflow_flag ^ r[7];
        end else if (op == OP_AND_IMMEDIATE) begin
            r = exp_accumulator & imm;
        end
        f.zero_flag = (r == 8'h00);
        if (w) begin
            mem_exp[a] = r;
        end else begin
            exp_accumulator = r;
        end
        r_valid = 1'b1;
        r_op = op;
        r_addr = a;
        r_imm = imm;
        @(negedge clk);
        chk(done, 1'b1);
        chk(accumulator, exp_accumulator);
        chk(mem_wr.we, w);
        if (w) begin
            chk({mem_wr.addr, mem_wr.data}, {a, r});
        end
        if (op == OP_ADD_TO_MEMORY) begin
            chk(flag_upd.en, FLAG_EN_ALL);
            chk(flag_upd.val, f);
        end else begin
            chk(flag_upd.en, FLAG_EN_ZERO);
            chk(flag_upd.val.zero_flag, f.zero_flag);
        end
    endtask : exec

    // Adds that overflow, carry, half-carry and wrap to zero
    task automatic scenario_add();
        load(8'h7f);
        exec(OP_ADD_TO_MEMORY, 8'h80, 8'h00);
        exec(OP_ADD_TO_MEMORY, 8'h07, 8'h00);
        r_valid = 1'b0;
        load(8'h01);
        exec(OP_ADD_TO_MEMORY, 8'h00, 8'h00);
        r_valid = 1'b0;
    endtask : scenario_add

    // AND forms back to back, last one with a load that must be refused
    task automatic scenario_and();
        load(8'hff);
        exec(OP_AND_FROM_MEMORY, 8'h3c, 8'h00);
        exec(OP_AND_TO_MEMORY, 8'h10, 8'h00);
        exec(OP_AND_IMMEDIATE, 8'h00, 8'h0f);
        exec(OP_AND_TO_MEMORY, 8'hff, 8'h00);
        exec(OP_AND_FROM_MEMORY, 8'h55, 8'h00);
        ld_valid = 1'b1;
        ld_data = 8'h55;
        exec(OP_AND_IMMEDIATE, 8'h00, 8'hf0);
        ld_valid = 1'b0;
    endtask : scenario_and

    // Undefined code with valid high leaves every output quiet
    task automatic scenario_unknown_op();
        r_valid = 1'b1;
        r_op = alu_op_e'(3'h7);
        @(negedge clk);
        chk({done, mem_wr.we, flag_upd.en}, 7'h00);
        chk(accumulator, exp_accumulator);
    endtask : scenario_unknown_op

    // Reset in mid-run drops a pending add and clears every output
    task automatic scenario_reset();
        rst_n = 1'b0;
        r_valid = 1'b1;
        r_op = OP_ADD_TO_MEMORY;
        r_addr = 8'h20;
        @(negedge clk);
        chk({accumulator, 7'h00, done}, 16'h0000);
        chk({mem_wr.we, flag_upd}, 11'h000);
        rst_n = 1'b1;
        r_valid = 1'b0;
        @(negedge clk);
        exp_accumulator = ACCUMULATOR_RESET;
        chk({accumulator, 7'h00, done}, {ACCUMULATOR_RESET, 8'h00});
        chk(mem_wr.we, 1'b0);
        exec(OP_ADD_TO_MEMORY, 8'h21, 8'h00);
        r_valid = 1'b0;
    endtask : scenario_reset

    // Every memory byte against the expected image
    task automatic scenario_readback();
        foreach (mem_exp[i]) begin
            r_addr = 8'(i);
            @(negedge clk);
            chk(rd_data, mem_exp[i]);
        end
    endtask : scenario_readback

    initial begin
        #200us;
        miscompares++;
        wrap_up();
    end

    initial begin
        {r_valid, ld_valid, r_addr, r_imm, ld_data} = '0;
        r_op = OP_NONE;
        rst_n = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem_exp[i] = ~8'(i);
        end
        repeat (20) @(negedge clk);
        chk({accumulator, 7'h00, done}, 16'h0000);
        chk({mem_wr.we, flag_upd}, 11'h000);
        rst_n = 1'b1;
        @(negedge clk);
        scenario_add();
        scenario_and();
        scenario_unknown_op();
        scenario_reset();
        scenario_readback();
        wrap_up();
    end
endmodule : test_add_and_memory_alu_ops
